/* File: rtl/pscl_params.svh */
// Register offsets, field positions, reset values and timing counts for the PHY stat block
`ifndef PSCL_PARAMS_SVH
`define PSCL_PARAMS_SVH

// Register indices; byte address is four times the index
`define PSCL_IDX_FALSE_CARRIER 6'h13
`define PSCL_IDX_DISCONNECT 6'h14
`define PSCL_IDX_ERROR_FRAME 6'h15
`define PSCL_IDX_SYMBOL_ERROR 6'h16
`define PSCL_IDX_EARLY_END 6'h17
`define PSCL_IDX_TENBASE_END 6'h18
`define PSCL_IDX_JABBER 6'h19
`define PSCL_IDX_LED_CTRL 6'h1B
`define PSCL_IDX_XOVER_CTRL 6'h1C

`define PSCL_NUM_CNT 7
`define PSCL_CNT_MAX 16'hFFFF

// Field positions, led_and_jabber_control
`define PSCL_LED_PROBE_BIT 5
`define PSCL_LED_JABDIS_BIT 3
`define PSCL_LED_SEL_RESET 3'h0
// Field positions, crossover_control
`define PSCL_XO_AUTO_BIT 7
`define PSCL_XO_MANUAL_BIT 6
`define PSCL_XO_STATUS_BIT 5
`define PSCL_XO_DONE_BIT 4
`define PSCL_XO_TIMER_RESET 4'h0

// Symbol errors in one run that count as one
`define PSCL_SYM_RUN_LEN 3'h6

// Timing
`define PSCL_CLK_HZ 40000000
`define PSCL_SLOT_MIN_MS 80
`define PSCL_SLOT_MAX_MS 105
`define PSCL_SLOT_STEPS 15
`define PSCL_SLOT_MIN_CYC ((`PSCL_SLOT_MIN_MS * (`PSCL_CLK_HZ / 1000)))
`define PSCL_SLOT_STEP_CYC \
  (((`PSCL_SLOT_MAX_MS - `PSCL_SLOT_MIN_MS) * (`PSCL_CLK_HZ / 1000) + `PSCL_SLOT_STEPS - 1) \
  / `PSCL_SLOT_STEPS)

`endif

/* File: rtl/pscl_pkg.sv */
// Types shared by the PHY stat, LED and crossover block
package pscl_pkg;

  typedef enum logic [2:0] {
    XO_MANUAL = 3'b001,
    XO_SEEK = 3'b010,
    XO_DONE = 3'b100
  } pscl_xo_state_t;

  typedef logic [15:0] pscl_cnt_t;

endpackage

/* File: rtl/pscl_top.sv */
// PHY event counters, LED select and MDI/MDI-X crossover control behind an AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pscl_params.svh"

module pscl_top import pscl_pkg::*; #(
  parameter logic [22:0] SLOT_BASE_CYCLES = 23'(`PSCL_SLOT_MIN_CYC), // 80 ms slot
  parameter logic [22:0] SLOT_STEP_CYCLES = 23'(`PSCL_SLOT_STEP_CYC) // Per timer code step
) (
  input wire logic clk, // 40 MHz core clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic hready, // AHB bus ready
  input wire logic [31:0] hwdata, // AHB write data
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic ev_false_carrier, // False carrier event pulse
  input wire logic ev_disconnect, // Disconnect event pulse
  input wire logic rx_frame_active, // High while a 100 Mbps frame is received
  input wire logic rx_frame_err, // Receive error pulse within a frame
  input wire logic sym_strobe, // One pulse per received symbol
  input wire logic sym_bad, // Symbol in this strobe is bad
  input wire logic ev_early_end, // Premature end of frame pulse
  input wire logic ev_tenbase_end, // 10BASE-T end of frame error pulse
  input wire logic ev_jabber, // Transmit jabber detect pulse
  input wire logic st_activity, // Activity indication
  input wire logic st_link, // Link indication
  input wire logic st_speed, // Speed indication, high at 100 Mbps
  input wire logic st_collision, // Collision indication
  output logic activity_led_out_n, // Activity LED, active low
  output logic link_led_out_n, // Link LED, active low
  output logic rx_jabber_disable, // Disables 100 Mbps carrier sense disconnect
  output logic mdix_select // High selects crossover pairs
);

  localparam int CN = `PSCL_NUM_CNT;

  // Counter slot order follows register order 19..25
  pscl_cnt_t cnt_q [CN];
  logic [CN-1:0] ev;
  logic [CN-1:0] rd_clr;
  logic err_seen_q;
  logic [2:0] run_q;
  logic sym_count, frame_count;
  logic [2:0] led_sel_q, led_sel_d;
  logic led_probe_q, led_probe_d;
  logic jab_dis_q, jab_dis_d;
  logic xo_auto_q, xo_auto_d;
  logic xo_manual_q, xo_manual_d;
  logic [3:0] xo_timer_q, xo_timer_d;
  pscl_xo_state_t xo_state_q;
  logic [22:0] slot_cnt_q, slot_len;
  logic mdix_q;
  logic wr_pend_q;
  logic [5:0] wr_idx_q, acc_idx;
  logic acc_take, rd_take;
  logic [15:0] rd_val;

  function automatic pscl_cnt_t sat_next(input pscl_cnt_t cur, input logic inc, input logic clr);
    pscl_cnt_t nv;
    nv = cur;
    if (clr) begin
      nv = {15'h0000, inc};
    end else if (inc && (cur != `PSCL_CNT_MAX)) begin
      nv = cur + 16'h0001;
    end
    return nv;
  endfunction

  function automatic logic [5:0] reg_index(input logic [31:0] a);
    return a[7:2];
  endfunction

  // Bus address phase
  assign acc_take = hsel && hready && htrans[1];
  assign rd_take = acc_take && !hwrite;
  assign acc_idx = reg_index(haddr);

  // Frame error: first error in a frame only
  assign frame_count = rx_frame_err && rx_frame_active && !err_seen_q;
  // Symbol run: first bad symbol of every six-long run is counted
  assign sym_count = sym_strobe && sym_bad && (run_q == 3'h0);

  assign ev = {ev_jabber, ev_tenbase_end, ev_early_end, sym_count, frame_count,
               ev_disconnect, ev_false_carrier};

  always_comb begin
    for (int i = 0; i < CN; i++) begin
      rd_clr[i] = rd_take && (acc_idx == (`PSCL_IDX_FALSE_CARRIER + 6'(i)));
    end
  end

  // Saturating, clear-on-read counters; an event in the read cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CN; i++) begin
        cnt_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < CN; i++) begin
        cnt_q[i] <= sat_next(cnt_q[i], ev[i], rd_clr[i]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_seen_q <= 1'b0;
    end else if (!rx_frame_active) begin
      err_seen_q <= 1'b0;
    end else if (rx_frame_err) begin
      err_seen_q <= 1'b1;
    end
  end

  // Run position resets on a good symbol and outside frames
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q <= 3'h0;
    end else if (!rx_frame_active) begin
      run_q <= 3'h0;
    end else if (sym_strobe) begin
      if (!sym_bad) begin
        run_q <= 3'h0;
      end else if (run_q == `PSCL_SYM_RUN_LEN - 3'h1) begin
        run_q <= 3'h0;
      end else begin
        run_q <= run_q + 3'h1;
      end
    end
  end

  // Write data phase; next values are also used by the read mux so that a
  // read right after a write sees the new value without a wait state
  always_comb begin
    led_sel_d = led_sel_q;
    led_probe_d = led_probe_q;
    jab_dis_d = jab_dis_q;
    xo_auto_d = xo_auto_q;
    xo_manual_d = xo_manual_q;
    xo_timer_d = xo_timer_q;
    if (wr_pend_q && (wr_idx_q == `PSCL_IDX_LED_CTRL)) begin
      led_sel_d = hwdata[2:0];
      led_probe_d = hwdata[`PSCL_LED_PROBE_BIT];
      jab_dis_d = hwdata[`PSCL_LED_JABDIS_BIT];
    end
    if (wr_pend_q && (wr_idx_q == `PSCL_IDX_XOVER_CTRL)) begin
      xo_auto_d = hwdata[`PSCL_XO_AUTO_BIT];
      xo_manual_d = hwdata[`PSCL_XO_MANUAL_BIT];
      xo_timer_d = hwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 6'h00;
    end else begin
      wr_pend_q <= acc_take && hwrite;
      wr_idx_q <= acc_idx;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_sel_q <= `PSCL_LED_SEL_RESET;
      led_probe_q <= 1'b0;
      jab_dis_q <= 1'b0;
      xo_auto_q <= 1'b0;
      xo_manual_q <= 1'b0;
      xo_timer_q <= `PSCL_XO_TIMER_RESET;
    end else begin
      led_sel_q <= led_sel_d;
      led_probe_q <= led_probe_d;
      jab_dis_q <= jab_dis_d;
      xo_auto_q <= xo_auto_d;
      xo_manual_q <= xo_manual_d;
      xo_timer_q <= xo_timer_d;
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    rd_val = 16'h0000;
    for (int i = 0; i < CN; i++) begin
      if (acc_idx == (`PSCL_IDX_FALSE_CARRIER + 6'(i))) begin
        rd_val = cnt_q[i];
      end
    end
    if (acc_idx == `PSCL_IDX_LED_CTRL) begin
      rd_val = {10'h000, led_probe_d, 1'b0, jab_dis_d, led_sel_d};
    end
    if (acc_idx == `PSCL_IDX_XOVER_CTRL) begin
      rd_val = {8'h00, xo_auto_d, xo_manual_d, mdix_q, (xo_state_q == XO_DONE),
                xo_timer_d};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_take) begin
        hrdata <= {16'h0000, rd_val};
      end
    end
  end

  // LED function select, as {activity, link}; pins are active low
  function automatic logic [1:0] led_pins(input logic [2:0] sel, input logic a, l, s, x);
    logic [1:0] on;
    case (sel)
      3'h0: on = {a, l};
      3'h1: on = {s, x};
      3'h2: on = {s, l};
      3'h3: on = {a, x};
      3'h4: on = 2'h0;
      3'h5: on = 2'h1;
      3'h6: on = 2'h2;
      default: on = 2'h3;
    endcase
    return ~on;
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      activity_led_out_n <= 1'b1;
      link_led_out_n <= 1'b1;
    end else begin
      {activity_led_out_n, link_led_out_n} <= led_pins(led_sel_q, st_activity, st_link,
                                                       st_speed, st_collision);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_jabber_disable <= 1'b0;
    end else begin
      rx_jabber_disable <= jab_dis_q;
    end
  end

  // Crossover resolution: toggle pairs each slot until the link comes up
  assign slot_len = SLOT_BASE_CYCLES + 23'(xo_timer_q * SLOT_STEP_CYCLES);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xo_state_q <= XO_MANUAL;
      slot_cnt_q <= 23'h000000;
      mdix_q <= 1'b0;
    end else begin
      case (xo_state_q)
        XO_MANUAL: begin
          mdix_q <= xo_manual_q;
          slot_cnt_q <= 23'h000000;
          if (xo_auto_q) begin
            xo_state_q <= XO_SEEK;
          end
        end
        XO_SEEK: begin
          if (!xo_auto_q) begin
            xo_state_q <= XO_MANUAL;
          end else if (st_link) begin
            xo_state_q <= XO_DONE;
          end else if (slot_cnt_q >= slot_len - 23'h000001) begin
            slot_cnt_q <= 23'h000000;
            mdix_q <= !mdix_q;
          end else begin
            slot_cnt_q <= slot_cnt_q + 23'h000001;
          end
        end
        XO_DONE: begin
          slot_cnt_q <= 23'h000000;
          if (!xo_auto_q) begin
            xo_state_q <= XO_MANUAL;
          end else if (!st_link) begin
            xo_state_q <= XO_SEEK;
          end
        end
        default: begin
          xo_state_q <= XO_MANUAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mdix_select <= 1'b0;
    end else begin
      mdix_select <= mdix_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_FC_CLEAR: assert property (
    rd_clr[0] && !ev[0] |=> cnt_q[0] == 16'h0000 && hrdata[15:0] == $past(cnt_q[0]))
    else $error("false carrier count not cleared by read");
  AST_DISC_SAT: assert property (
    cnt_q[1] == 16'hFFFF && !rd_clr[1] |=> cnt_q[1] == 16'hFFFF)
    else $error("disconnect count wrapped");
  AST_FRAME_ONCE: assert property (
    rx_frame_active && err_seen_q && !rd_clr[2] |=> cnt_q[2] == $past(cnt_q[2]))
    else $error("error frame counted twice");
  AST_SYM_INC: assert property (
    ev[3] && !rd_clr[3] && cnt_q[3] != 16'hFFFF |=> cnt_q[3] == $past(cnt_q[3]) + 16'h0001)
    else $error("symbol error count did not add one");
  AST_SYM_RUN: assert property (
    rx_frame_active && sym_strobe && sym_bad && run_q == 3'h0 ##1
    (rx_frame_active && sym_strobe && sym_bad) [*5] |-> !sym_count)
    else $error("bad symbol run counted more than once");
  AST_EARLY_INC: assert property (
    ev[4] && !rd_clr[4] && cnt_q[4] != 16'hFFFF |=> cnt_q[4] != $past(cnt_q[4]))
    else $error("early end count did not move");
  AST_TENB_SAT: assert property (
    cnt_q[5] == 16'hFFFF && !rd_clr[5] |=> cnt_q[5] == 16'hFFFF)
    else $error("end of frame count wrapped");
  AST_JAB_CLEAR: assert property (
    rd_clr[6] && !ev[6] |=> cnt_q[6] == 16'h0000)
    else $error("jabber count not cleared by read");
  AST_JABDIS: assert property (
    ##1 rx_jabber_disable == $past(jab_dis_q))
    else $error("jabber disable output does not follow control");
  AST_LED_STATIC: assert property (
    led_sel_q == 3'h5 |=> !link_led_out_n && activity_led_out_n)
    else $error("static LED code not applied");
  AST_LED_FUNC: assert property (
    led_sel_q == 3'h1 |=> activity_led_out_n == !$past(st_speed))
    else $error("LED function select wrong");
  AST_MANUAL: assert property (
    xo_state_q == XO_MANUAL |=> mdix_q == $past(xo_manual_q) ##1 mdix_select == $past(mdix_q))
    else $error("manual crossover not applied");
  AST_DONE_LINK: assert property (
    xo_state_q == XO_DONE |-> $past(st_link))
    else $error("resolution complete without link");
  AST_EVENT_ON_READ: assert property (
    rd_clr[6] && ev[6] |=> cnt_q[6] == 16'h0001)
    else $error("event lost during clearing read");

endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the PHY event counter, LED select and crossover block
`timescale 1ns/1ps
`include "pscl_params.svh"

module testbench;
  // Short slot counts keep the crossover search within a few hundred cycles
  localparam logic [22:0] BASE = 23'h14;
  localparam logic [22:0] STEP = 23'h2;

  logic clk, sys_rst, hsel, hwrite, frm, ferr, sstb, sbad, act, lnk, spd, col;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] ev;
  logic hreadyout, hresp, act_n, lnk_n, jdis, mdix, m;
  logic [5:0] cidx [7];
  int n_errors, checks_done, seed, n, k;

  pscl_top #(.SLOT_BASE_CYCLES(BASE), .SLOT_STEP_CYCLES(STEP)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ev_false_carrier(ev[0]), .ev_disconnect(ev[1]),
    .rx_frame_active(frm), .rx_frame_err(ferr), .sym_strobe(sstb), .sym_bad(sbad),
    .ev_early_end(ev[2]), .ev_tenbase_end(ev[3]), .ev_jabber(ev[4]), .st_activity(act),
    .st_link(lnk), .st_speed(spd), .st_collision(col), .activity_led_out_n(act_n),
    .link_led_out_n(lnk_n), .rx_jabber_disable(jdis), .mdix_select(mdix));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; evp raises event inputs in the address phase cycle
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     input logic [4:0] evp);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, idx, 2'h0};
    hwrite <= wr;
    hsize <= 3'h2;
    ev <= evp;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ev <= 5'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wreg(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 5'h0);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, 5'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [4:0] msk, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      ev <= msk;
      @(posedge clk);
      ev <= 5'h0;
    end
  endtask

  task automatic errp();
    @(posedge clk);
    ferr <= 1'b1;
    @(posedge clk);
    ferr <= 1'b0;
  endtask

  // Back-to-back calls strobe one symbol every cycle; caller lowers the strobe
  task automatic sym(input logic b);
    @(posedge clk);
    sstb <= 1'b1;
    sbad <= b;
  endtask

  task automatic setfrm(input logic v);
    @(posedge clk);
    frm <= v;
  endtask

  // Active-low pair {activity, link} for a select code
  function automatic logic [1:0] led_exp(input logic [2:0] c, input logic a, l, s, x);
    logic [1:0] on;
    case (c)
      3'h0: on = {a, l};
      3'h1: on = {s, x};
      3'h2: on = {s, l};
      3'h3: on = {a, x};
      3'h4: on = 2'h0;
      3'h5: on = 2'h1;
      3'h6: on = 2'h2;
      default: on = 2'h3;
    endcase
    return ~on;
  endfunction

  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial begin
    {hsel, hwrite, frm, ferr, sstb, sbad, act, lnk, spd, col} = 10'h0;
    {haddr, hwdata, htrans, hsize, ev} = '0;
    sys_rst = 1'b1;
    seed = 32'h47F5;
    cidx = '{`PSCL_IDX_FALSE_CARRIER, `PSCL_IDX_DISCONNECT, `PSCL_IDX_EARLY_END,
             `PSCL_IDX_TENBASE_END, `PSCL_IDX_JABBER, `PSCL_IDX_ERROR_FRAME,
             `PSCL_IDX_SYMBOL_ERROR};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    chk({27'h0, hresp, act_n, lnk_n, jdis, mdix}, 32'hC);
    // Counters are read only: a write must not preload them
    for (int i = 0; i < 7; i++) begin
      wreg(cidx[i], 32'hFFFF);
      rchk(cidx[i], 32'h0);
    end
    rchk(6'h1A, 32'h0);
    rchk(`PSCL_IDX_LED_CTRL, 32'h0);
    rchk(`PSCL_IDX_XOVER_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      n = 1 + ($unsigned($random(seed)) % 20);
      pulse(5'h1 << i, n);
      rchk(cidx[i], 32'(n));
      rchk(cidx[i], 32'h0);
    end
    // Events held high every cycle run past full scale
    @(posedge clk);
    ev <= 5'h1F;
    repeat (65540) @(posedge clk);
    ev <= 5'h0;
    for (int i = 0; i < 5; i++) begin
      rchk(cidx[i], 32'hFFFF);
      rchk(cidx[i], 32'h0);
    end
    pulse(5'h10, 3);
    bus(1'b0, `PSCL_IDX_JABBER, 32'h0, 5'h10);
    chk(rd, 32'h3);
    rchk(`PSCL_IDX_JABBER, 32'h1);
    errp();
    setfrm(1'b1);
    repeat (3) errp();
    setfrm(1'b0);
    setfrm(1'b1);
    errp();
    setfrm(1'b0);
    rchk(`PSCL_IDX_ERROR_FRAME, 32'h2);
    // Runs of 7, 3 and 6 bad symbols, broken by good ones
    setfrm(1'b1);
    repeat (7) sym(1'b1);
    sym(1'b0);
    repeat (3) sym(1'b1);
    sym(1'b0);
    repeat (6) sym(1'b1);
    @(posedge clk);
    sstb <= 1'b0;
    setfrm(1'b0);
    rchk(`PSCL_IDX_SYMBOL_ERROR, 32'h4);
    // Probe mapping bit is always written as zero
    wreg(`PSCL_IDX_LED_CTRL, 32'hFFCF);
    rchk(`PSCL_IDX_LED_CTRL, 32'hF);
    repeat (2) @(posedge clk);
    chk({31'h0, jdis}, 32'h1);
    for (int c = 0; c < 8; c++) begin
      wreg(`PSCL_IDX_LED_CTRL, 32'(c));
      repeat (4) begin
        @(posedge clk);
        {act, lnk, spd, col} <= 4'($random(seed));
        repeat (2) @(posedge clk);
        chk({30'h0, act_n, lnk_n}, {30'h0, led_exp(3'(c), act, lnk, spd, col)});
      end
    end
    chk({31'h0, jdis}, 32'h0);
    @(posedge clk);
    lnk <= 1'b0;
    wreg(`PSCL_IDX_XOVER_CTRL, 32'h40);
    repeat (3) @(posedge clk);
    chk({31'h0, mdix}, 32'h1);
    rchk(`PSCL_IDX_XOVER_CTRL, 32'h60);
    wreg(`PSCL_IDX_XOVER_CTRL, 32'hFF00);
    rchk(`PSCL_IDX_XOVER_CTRL, 32'h0);
    for (int t = 0; t < 4; t += 3) begin
      wreg(`PSCL_IDX_XOVER_CTRL, 32'h80 | t);
      m = mdix;
      do @(posedge clk); while (mdix === m);
      m = mdix;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (mdix === m);
      chk(32'(k), 32'(BASE + t * STEP));
    end
    // Once linked the search must stop switching pairs
    @(posedge clk);
    lnk <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, `PSCL_IDX_XOVER_CTRL, 32'h0, 5'h0);
    chk({28'h0, rd[7], rd[4], rd[5], mdix}, {28'h0, 2'h3, mdix, mdix});
    chk({28'h0, rd[3:0]}, 32'h3);
    m = mdix;
    repeat (60) @(posedge clk);
    chk({31'h0, mdix}, {31'h0, m});
    @(posedge clk);
    lnk <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, `PSCL_IDX_XOVER_CTRL, 32'h0, 5'h0);
    chk({31'h0, rd[4]}, 32'h0);
    end_sim();
  end
endmodule
